// >>> rtl/srw_supervisor.sv
/*
 Reset supervisor with watchdog: generates active-low and active-high resets for a processor.
 Assumes manual reset and watchdog inputs are synchronous to clk; supply comparator arrives as an asynchronous digital level.
*/
// Functional notes
// - Reset output goes low on supply low, manual reset low, or watchdog expiry.
// - After each cause clears, reset stays asserted for the full reset timeout.
// - Active-high reset output mirrors the active-low one with the same timing.
// - Reset holds while manual reset is low, then a further full timeout.
// - Watchdog input must toggle within timeout, else a timed reset is issued.
// - Watchdog counter clears on reset, manual reset, and any watchdog input edge.
// - Watchdog counter is held at zero during reset and restarts from zero as soon as reset releases.
// - Watchdog pulses of 150 ns or longer count as valid edges.
`timescale 1ns/1ps
`include "srw_consts.svh"

module srw_supervisor #(
	parameter logic [`SRW_CNT_W-1:0] RESET_CYC = `SRW_RESET_CYC_DEF,
	parameter logic [`SRW_CNT_W-1:0] WDOG_CYC = `SRW_WDOG_CYC_DEF
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic supply_low,
	input wire logic manual_reset_n,
	input wire logic watchdog_kick_in,
	output srw_pkg::srw_reset_out_type reset_out
);
	import srw_pkg::*;

	logic supply_low_s1_r;
	logic supply_low_s2_r;
	logic kick_prev_r;
	logic kick_edge;
	logic hold_cause;
	logic wdog_expire;
	srw_state_type state_r;
	logic [`SRW_CNT_W-1:0] rst_cnt_r;
	logic [`SRW_CNT_W-1:0] wdog_cnt_r;
	srw_reset_out_type out_r;

	// Two-stage synchroniser for the comparator level; first stage feeds only the second
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			supply_low_s1_r <= 1'b1;
			supply_low_s2_r <= 1'b1;
		end else begin
			supply_low_s1_r <= supply_low;
			supply_low_s2_r <= supply_low_s1_r;
		end
	end

	// Single-cycle sampling catches any pulse of 150 ns (3 cycles) or longer
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			kick_prev_r <= 1'b0;
		end else begin
			kick_prev_r <= watchdog_kick_in;
		end
	end

	assign kick_edge = watchdog_kick_in ^ kick_prev_r;
	assign hold_cause = supply_low_s2_r || !manual_reset_n;
	assign wdog_expire = (state_r == SRW_ST_RUN) && (wdog_cnt_r >= WDOG_CYC - 1'b1) && !kick_edge;

	// Reset sequencer: hold while a cause is present, then count the timeout
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= SRW_ST_HOLD;
			rst_cnt_r <= '0;
		end else begin
			case (state_r)
				SRW_ST_HOLD: begin
					rst_cnt_r <= '0;
					if (!hold_cause) begin
						state_r <= SRW_ST_TIMEOUT;
					end
				end
				SRW_ST_TIMEOUT: begin
					if (hold_cause) begin
						state_r <= SRW_ST_HOLD;
						rst_cnt_r <= '0;
					end else if (rst_cnt_r >= RESET_CYC - 1'b1) begin
						state_r <= SRW_ST_RUN;
						rst_cnt_r <= '0;
					end else begin
						rst_cnt_r <= rst_cnt_r + 1'b1;
					end
				end
				SRW_ST_RUN: begin
					rst_cnt_r <= '0;
					if (hold_cause) begin
						state_r <= SRW_ST_HOLD;
					end else if (wdog_expire) begin
						// Expiry goes straight to the timed phase; no cause remains to hold on
						state_r <= SRW_ST_TIMEOUT;
					end
				end
				default: begin
					state_r <= SRW_ST_HOLD;
					rst_cnt_r <= '0;
				end
			endcase
		end
	end

	// Watchdog counter only runs while reset is released
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wdog_cnt_r <= '0;
		end else if (state_r != SRW_ST_RUN || hold_cause || kick_edge) begin
			wdog_cnt_r <= '0;
		end else if (wdog_expire) begin
			wdog_cnt_r <= '0;
		end else begin
			wdog_cnt_r <= wdog_cnt_r + 1'b1;
		end
	end

	// Outputs are registered; asserted unless next state is running
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_r <= '{reset_n: 1'b0, reset: 1'b1};
		end else begin
			if (state_r == SRW_ST_RUN && !hold_cause && !wdog_expire) begin
				out_r <= '{reset_n: 1'b1, reset: 1'b0};
			end else if (state_r == SRW_ST_TIMEOUT && !hold_cause && rst_cnt_r >= RESET_CYC - 1'b1) begin
				out_r <= '{reset_n: 1'b1, reset: 1'b0};
			end else begin
				out_r <= '{reset_n: 1'b0, reset: 1'b1};
			end
		end
	end

	assign reset_out = out_r;
endmodule

// >>> include/srw_consts.svh
/*
 Constants for the reset supervisor with watchdog: timing figures and derived cycle counts.
 Assumes a 20 MHz system clock.
*/
`ifndef SRW_CONSTS_SVH
`define SRW_CONSTS_SVH
`define SRW_CLK_HZ 20000000
`define SRW_MIN_PULSE_NS 150
`define SRW_MIN_PULSE_CYC ((`SRW_MIN_PULSE_NS * 20 + 999) / 1000)
`define SRW_RESET_CYC_DEF 32'd800000
`define SRW_WDOG_CYC_DEF 32'd32000000
`define SRW_CNT_W 32
`endif

// >>> include/srw_pkg.sv
/*
 Types for the reset supervisor with watchdog.
 Assumes the constants header is available on the include path.
*/
package srw_pkg;
	typedef enum logic [1:0] {
		SRW_ST_HOLD,
		SRW_ST_TIMEOUT,
		SRW_ST_RUN
	} srw_state_type;

	typedef struct packed {
		logic reset_n;
		logic reset;
	} srw_reset_out_type;
endpackage

// >>> tb/srw_monitor.sv
/* Port checker for the supervisor; assumes the bench sets short timeouts. */
`timescale 1ns/1ps
module srw_monitor #(parameter int RESET_CYC = 20, parameter int WDOG_CYC = 50) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic supply_low,
	input wire logic manual_reset_n,
	input wire logic watchdog_kick_in,
	input srw_pkg::srw_reset_out_type reset_out
);
	logic [7:0] q_r;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Cycles of run with a steady kick line; bounded by the expiry count
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n) q_r <= 8'h00;
		else q_r <= (reset_out.reset_n && watchdog_kick_in == $past(watchdog_kick_in)) ? q_r + 8'h01 : 8'h00;
	a_mr_low: assert property (!manual_reset_n |=> reset_out.reset) else $error("mr");
	a_out_pair: assert property (reset_out.reset != reset_out.reset_n) else $error("pair");
	a_supply_low: assert property (supply_low |-> ##[1:3] !reset_out.reset_n) else $error("sup");
	a_supply_hold: assert property ($past(supply_low, 4) |-> reset_out.reset) else $error("hold");
	a_mr_hold: assert property ($rose(manual_reset_n) |-> !reset_out.reset_n [*8]) else $error("mrh");
	a_full_timeout: assert property ($rose(reset_out.reset_n) |-> $past(manual_reset_n, RESET_CYC)
		&& !$past(reset_out.reset_n, RESET_CYC)) else $error("short");
	a_wdog_bound: assert property (q_r <= WDOG_CYC + 2) else $error("wd");
	a_no_early: assert property ($fell(reset_out.reset_n) |-> !$past(manual_reset_n)
		|| $past(supply_low, 3) || q_r >= WDOG_CYC - 4) else $error("early");
endmodule
bind srw_supervisor srw_monitor #(.RESET_CYC(RESET_CYC), .WDOG_CYC(WDOG_CYC)) srw_monitor_inst (.clk, .rst_n,
	.supply_low, .manual_reset_n, .watchdog_kick_in, .reset_out);

// >>> tb/srw_cpu_model.sv
/* Processor model: toggles the kick line every gap+1 run cycles; assumes gap from the bench. */
`timescale 1ns/1ps
module srw_cpu_model (
	input wire logic clk,
	input srw_pkg::srw_reset_out_type reset_out,
	input wire logic [7:0] gap,
	output logic watchdog_kick_in = 1'b0
);
	logic [7:0] n_r = 8'h00;
	always @(posedge clk) begin
		n_r <= (!reset_out.reset_n || n_r >= gap) ? 8'h00 : n_r + 8'h01;
		if (reset_out.reset_n && n_r >= gap) watchdog_kick_in <= !watchdog_kick_in;
	end
endmodule

// >>> tb/supervisor_reset_watchdog_bench.sv
/* Bench: causes, random kicks and a stall; assumes the checker is bound in. */
`timescale 1ns/1ps
module supervisor_reset_watchdog_bench;
	logic clk = 1'b0, rst_n = 1'b0, supply_low = 1'b0, manual_reset_n = 1'b0, st = 1'b0, watchdog_kick_in;
	logic [7:0] gap = 8'h05, lo_r = 8'h00;
	srw_pkg::srw_reset_out_type reset_out;
	int seed = 32'h21bcfada, miscompares = 0, n_checks = 0, cyc = 0, q[$];
	// Release lags a clear cause by one cycle, two more for the supply synchroniser
	localparam int RST = 20;
	always #25 clk = !clk;
	srw_supervisor #(.RESET_CYC(32'h14), .WDOG_CYC(32'h32)) srw_supervisor_inst (.clk, .rst_n, .supply_low,
		.manual_reset_n, .watchdog_kick_in, .reset_out);
	srw_cpu_model srw_cpu_model_inst (.clk, .reset_out, .gap, .watchdog_kick_in);
	task report_and_stop;
		if (miscompares == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input logic [7:0] s, e);
		n_checks++;
		miscompares += (s !== e);
		if (s !== e) $display("[ERR] %0t seen %h expected %h", $time, s, e);
	endtask
	task cause(input logic sup, input int n, e);
		q.push_back(e);
		{supply_low, manual_reset_n} <= {sup, sup};
		repeat (n) @(posedge clk);
		{supply_low, manual_reset_n} <= 2'b01;
		repeat (e + 60) @(posedge clk);
	endtask
	// Low time counts from the first edge that sees every cause gone
	always @(posedge clk) begin
		cyc++;
		gap <= st ? 8'hFF : 8'($unsigned($random(seed)) % 40);
		lo_r <= (!rst_n || !manual_reset_n || supply_low || reset_out.reset_n) ? 8'h00 : lo_r + 8'h01;
		if (reset_out.reset_n && lo_r != 8'h00) begin
			chk(lo_r, 8'(q.size() ? q.pop_front() : 0));
			chk(8'(reset_out.reset), 8'h00);
		end
		miscompares += (cyc > 32'h1000);
		if (cyc > 32'h1000) report_and_stop();
	end
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 16; i++) cause(i[0], 3 + $unsigned($random(seed)) % 6, i[0] ? RST + 3 : RST + 1);
		q.push_back(RST);
		st <= 1'b1;
		repeat (78) @(posedge clk);
		chk(8'(q.size()), 8'h00);
		report_and_stop();
	end
endmodule
